// *** hw/core_ext_regs.vh ***
// constants for the enhanced core: file addresses, flag positions, resets
`ifndef CORE_EXT_REGS_VH
`define CORE_EXT_REGS_VH
// core file register addresses (low 7 bits, mirrored in every bank)
`define ADDR_STATUS         7'h03
`define ADDR_PTR0_LOW       7'h04
`define ADDR_PTR0_HIGH      7'h05
`define ADDR_PTR1_LOW       7'h06
`define ADDR_PTR1_HIGH      7'h07
`define ADDR_BANK_SEL       7'h08
`define ADDR_WORK_REG       7'h09
`define ADDR_PC_HIGH        7'h0a
`define ADDR_IRQ_CTRL       7'h0b
// shadow registers, bank 31 full addresses
`define SHADOW_BANK         5'h1f
`define ADDR_STATUS_SHADOW  12'hfe4
`define ADDR_WORK_SHADOW    12'hfe5
`define ADDR_BANK_SHADOW    12'hfe6
`define ADDR_PAGE_SHADOW    12'hfe7
`define ADDR_PTR0L_SHADOW   12'hfe8
`define ADDR_PTR0H_SHADOW   12'hfe9
`define ADDR_PTR1L_SHADOW   12'hfea
`define ADDR_PTR1H_SHADOW   12'hfeb
// status flag positions (no legacy bank bits)
`define ST_CARRY            0
`define ST_DIGIT            1
`define ST_ZERO             2
// irq control bit position
`define IRQ_GIE             7
// alu operation codes
`define ALU_ADD             4'h0
`define ALU_ADDC            4'h1
`define ALU_SUB             4'h2
`define ALU_SUBB            4'h3
`define ALU_ROT_L           4'h4
`define ALU_ROT_R           4'h5
`define ALU_ASR             4'h6
`define ALU_LSR             4'h7
`define ALU_LSL             4'h8
`define ALU_PASS            4'h9
// instruction kinds presented by the decoder
`define OP_NONE             4'h0
`define OP_LOAD_BANK        4'h1
`define OP_LOAD_PAGE        4'h2
`define OP_ALU_FILE         4'h3
`define OP_WRITE_FILE       4'h4
`define OP_JUMP             4'h5
`define OP_CALL             4'h6
`define OP_RETURN           4'h7
`define OP_RET_IRQ          4'h8
`define OP_SW_RESET         4'h9
`define OP_SET_GIE          4'ha
// reset values
`define RST_VECTOR          15'h0000
`define IRQ_VECTOR          15'h0004
`define STACK_DEPTH         16
`endif

// *** hw/shift_alu.v ***
// byte alu: add/sub with carry, rotates and shifts
`include "core_ext_regs.vh"
module shift_alu (
	input  wire [3:0] op,
	input  wire [7:0] file_val,
	input  wire [7:0] work_val,
	input  wire       carry_in,
	output reg  [7:0] result,
	output reg        carry_out,
	output reg        digit_out
);
	reg [8:0] sum;
	reg [4:0] nib;
	// carry convention: subtract sets carry when no borrow occurs
	always @* begin
		sum       = 9'h000;
		nib       = 5'h00;
		result    = file_val;
		carry_out = carry_in;
		digit_out = 1'b0;
		case (op)
		`ALU_ADD, `ALU_ADDC: begin
			sum = {1'b0, file_val} + {1'b0, work_val} +
				{8'h00, (op == `ALU_ADDC) & carry_in}; // RQ5
			nib = {1'b0, file_val[3:0]} + {1'b0, work_val[3:0]} +
				{4'h0, (op == `ALU_ADDC) & carry_in};
			result    = sum[7:0];
			carry_out = sum[8];
			digit_out = nib[4];
		end
		`ALU_SUB, `ALU_SUBB: begin
			// f - w - borrow, borrow is inverted carry
			sum = {1'b0, file_val} + {1'b0, ~work_val} +
				{8'h00, (op == `ALU_SUB) | carry_in}; // RQ5
			nib = {1'b0, file_val[3:0]} + {1'b0, ~work_val[3:0]} +
				{4'h0, (op == `ALU_SUB) | carry_in};
			result    = sum[7:0];
			carry_out = sum[8];
			digit_out = nib[4];
		end
		`ALU_ROT_L: begin
			result    = {file_val[6:0], carry_in}; // RQ6
			carry_out = file_val[7];
		end
		`ALU_ROT_R: begin
			result    = {carry_in, file_val[7:1]}; // RQ6
			carry_out = file_val[0];
		end
		`ALU_ASR: begin
			result    = {file_val[7], file_val[7:1]}; // RQ7
			carry_out = file_val[0];
		end
		`ALU_LSR: begin
			result    = {1'b0, file_val[7:1]}; // RQ8
			carry_out = file_val[0];
		end
		`ALU_LSL: begin
			// the arithmetic left alias decodes to this same code
			result    = {file_val[6:0], 1'b0}; // RQ9
			carry_out = file_val[7];
		end
		default: begin
			result    = file_val;
			carry_out = carry_in;
		end
		endcase
	end
endmodule // shift_alu

// *** hw/return_stack.v ***
// return address stack with overflow and underflow detection
`include "core_ext_regs.vh"
module return_stack (
	input  wire        clk,
	input  wire        rst,
	input  wire        push,
	input  wire        pop,
	input  wire [14:0] push_addr,
	output wire [14:0] top_addr,
	output reg         overflow_r,
	output reg         underflow_r
);
	reg [14:0] entry_r [0:`STACK_DEPTH-1];
	reg [4:0]  depth_r;
	wire [3:0] top_idx = depth_r[3:0] - 4'h1;
	assign top_addr = entry_r[top_idx];
	genvar i;
	// one flip-flop word per entry, written at the slot named by the low four depth bits
	generate
		for (i = 0; i < `STACK_DEPTH; i = i + 1) begin : g_ent
			localparam [3:0] SLOT = i;
			always @(posedge clk) begin
				if (rst)
					entry_r[i] <= 15'h0000;
				else if (push && depth_r[3:0] == SLOT)
					entry_r[i] <= push_addr;
			end
		end
	endgenerate
	// depth counter; events flagged for one cycle
	always @(posedge clk) begin
		if (rst) begin
			depth_r     <= 5'h00;
			overflow_r  <= 1'b0;
			underflow_r <= 1'b0;
		end else begin
			overflow_r  <= push && depth_r == 5'h10;
			underflow_r <= pop && depth_r == 5'h00;
			if (push && depth_r != 5'h10)
				depth_r <= depth_r + 5'h01;
			else if (pop && depth_r != 5'h00)
				depth_r <= depth_r - 5'h01;
		end
	end
endmodule // return_stack

// *** hw/core_ext.v ***
// enhanced core: banking, paging, alu, context shadows and reset causes
// Overview of operation
// [RQ1] five-bit bank select loaded from a literal in one cycle
// [RQ2] page latch loaded with seven literal bits, top four select sixteen pages
// [RQ3] call/jump keeps 11 target bits; upper bits from the page latch
// [RQ4] page load then call or jump reaches all memory in 2 cycles
// [RQ5] add/subtract with carry work on file and work register only
// [RQ6] rotates go through carry over nine bits
// [RQ7] arithmetic right shift copies the sign bit, low bit to carry
// [RQ8] logical right shift brings in zero, low bit to carry
// [RQ9] logical left shift brings in zero, top bit to carry; alias same
// [RQ10] work register readable and writable as a file register
// [RQ11] interrupt entry saves context to shadows, return restores it
// [RQ12] shadows sit at fixed bank 31 addresses 0xfe4 to 0xfeb
// [RQ13] software writes to shadows change what return restores; only the write instruction does so, alu results go to the outside write port
// [RQ14] reset instruction resets the whole core at once
// [RQ15] stack overflow or underflow resets when enabled
// [RQ16] reset cause flags: overflow, underflow, instruction, power, pin
// [RQ17] instruction after setting interrupt enable always executes
// [RQ18] pointers are 16 bits with separately addressed high bytes
// [RQ19] status holds no bank bits; banking only from bank select
// [RQ20] of the two returns, only interrupt return restores shadows and sets enable
`include "core_ext_regs.vh"
module core_ext (
	input  wire        clk,
	input  wire        rst,
	input  wire        power_on,
	input  wire        external_clear_pin,
	input  wire        stack_reset_en,
	input  wire        irq_req,
	input  wire [3:0]  op_kind,
	input  wire [3:0]  alu_op,
	input  wire [10:0] literal,
	input  wire [6:0]  file_addr,
	input  wire        dest_file,
	input  wire [7:0]  file_rdata,
	input  wire [7:0]  write_data,
	output reg  [14:0] pc_r,
	output reg  [7:0]  status_r,
	output reg  [7:0]  work_r,
	output reg  [4:0]  bank_sel_r,
	output reg  [6:0]  pc_high_latch_r,
	output reg  [15:0] pointer0_r,
	output reg  [15:0] pointer1_r,
	output reg         global_irq_enable_r,
	output reg  [7:0]  file_wdata_r,
	output reg         file_we_r,
	output reg  [4:0]  reset_cause_r,
	output reg         core_reset_r,
	output reg  [7:0]  file_read_r
);
	////////////////////////////////////////////////////////////////////
	// state
	// one-hot states: run, and the dead cycle after interrupt entry
	localparam ST_RUN  = 2'b01;
	localparam ST_IRQ  = 2'b10;
	reg [1:0]  state_r;
	// eight shadow bytes, status copy first, pointer1 high last
	reg [7:0]  shadow_r [0:7];
	reg        gie_hold_r;
	reg        sw_reset_r;
	wire [11:0] full_addr = {bank_sel_r, file_addr}; // RQ19
	// shadow window: eight words upward from the status copy
	wire [11:0] shadow_off = full_addr - `ADDR_STATUS_SHADOW;
	wire        is_shadow  = full_addr >= `ADDR_STATUS_SHADOW &&
		full_addr <= `ADDR_PTR1H_SHADOW; // RQ12
	wire [2:0]  shadow_idx = shadow_off[2:0]; // RQ12
	// stack and alu results
	wire stack_ovf;
	wire stack_unf;
	wire [14:0] stack_top;
	wire [7:0]  alu_res;
	wire        alu_c;
	wire        alu_dc;
	reg  [7:0]  file_val;
	////////////////////////////////////////////////////////////////////
	// file read mux, work register and pointers visible as files
	always @* begin
		case (file_addr)
		`ADDR_WORK_REG:  file_val = work_r; // RQ10
		`ADDR_PTR0_LOW:  file_val = pointer0_r[7:0];
		`ADDR_PTR0_HIGH: file_val = pointer0_r[15:8]; // RQ18
		`ADDR_PTR1_LOW:  file_val = pointer1_r[7:0];
		`ADDR_PTR1_HIGH: file_val = pointer1_r[15:8]; // RQ18
		`ADDR_BANK_SEL:  file_val = {3'h0, bank_sel_r};
		`ADDR_PC_HIGH:   file_val = {1'b0, pc_high_latch_r};
		`ADDR_STATUS:    file_val = status_r;
		`ADDR_IRQ_CTRL:  file_val = {global_irq_enable_r, 7'h00};
		default:         file_val = is_shadow ? shadow_r[shadow_idx]
			: file_rdata; // RQ12
		endcase
	end
	////////////////////////////////////////////////////////////////////
	// alu on the selected file operand; carry feeds rotates and add/subtract with carry
	shift_alu u_alu (
		.op        (alu_op),
		.file_val  (file_val),
		.work_val  (work_r),
		.carry_in  (status_r[`ST_CARRY]),
		.result    (alu_res),
		.carry_out (alu_c),
		.digit_out (alu_dc)
	);
	// stack traffic; a return pops unless entry pushes in the same cycle
	wire do_call = state_r == ST_RUN && op_kind == `OP_CALL;
	wire do_ret  = state_r == ST_RUN &&
		(op_kind == `OP_RETURN || op_kind == `OP_RET_IRQ);
	// interrupt taken only when enabled and not right after enable set
	wire take_irq = state_r == ST_RUN && irq_req &&
		global_irq_enable_r && !gie_hold_r; // RQ17
	// entry saves the pc of the skipped instruction, a call the next one
	wire [14:0] ret_addr = take_irq ? pc_r : pc_r + 15'h0001;
	////////////////////////////////////////////////////////////////////
	// return stack: sixteen entries, faults flagged for one cycle
	return_stack u_stack (
		.clk         (clk),
		.rst         (rst | core_reset_r),
		.push        (do_call | take_irq),
		.pop         (do_ret & ~take_irq),
		.push_addr   (ret_addr),
		.top_addr    (stack_top),
		.overflow_r  (stack_ovf),
		.underflow_r (stack_unf)
	);
	// a stack fault only resets the core when the user enabled it
	wire stack_fault = stack_reset_en && (stack_ovf || stack_unf); // RQ15
	wire any_reset = rst | core_reset_r;
	////////////////////////////////////////////////////////////////////
	// reset request: software or stack fault pulse a full core reset
	always @(posedge clk) begin
		if (rst) begin
			core_reset_r <= 1'b0;
			sw_reset_r   <= 1'b0;
		end else begin
			core_reset_r <= sw_reset_r | stack_fault; // RQ14
			sw_reset_r   <= !core_reset_r && state_r == ST_RUN &&
				op_kind == `OP_SW_RESET; // RQ14
		end
	end
	// reset cause flags survive core resets; the external reset wins over a set
	always @(posedge clk) begin
		if (rst)
			reset_cause_r <= 5'h00;
		else begin
			// flags are only set here; the external reset alone clears them
			if (power_on)
				reset_cause_r[3] <= 1'b1; // RQ16
			if (external_clear_pin)
				reset_cause_r[4] <= 1'b1; // RQ16
			if (stack_ovf && stack_reset_en)
				reset_cause_r[0] <= 1'b1; // RQ16
			if (stack_unf && stack_reset_en)
				reset_cause_r[1] <= 1'b1; // RQ16
			if (sw_reset_r)
				reset_cause_r[2] <= 1'b1; // RQ16
		end
	end
	////////////////////////////////////////////////////////////////////
	// shadow registers, one per index
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_shadow
			localparam [2:0] SLOT = g;
			reg [7:0] live;
			always @* begin
				case (g)
				0:       live = status_r;
				1:       live = work_r;
				2:       live = {3'h0, bank_sel_r};
				3:       live = {1'b0, pc_high_latch_r};
				4:       live = pointer0_r[7:0];
				5:       live = pointer0_r[15:8];
				6:       live = pointer1_r[7:0];
				default: live = pointer1_r[15:8];
				endcase
			end
			always @(posedge clk) begin
				if (any_reset)
					shadow_r[g] <= 8'h00;
				else if (take_irq)
					shadow_r[g] <= live; // RQ11
				else if (state_r == ST_RUN &&
					op_kind == `OP_WRITE_FILE && is_shadow &&
					shadow_idx == SLOT)
					shadow_r[g] <= write_data; // RQ13
			end
		end
	endgenerate
	////////////////////////////////////////////////////////////////////
	// core registers and program counter
	always @(posedge clk) begin
		if (any_reset) begin
			// status comes up with its two fixed flags set
			state_r             <= ST_RUN;
			pc_r                <= `RST_VECTOR;
			status_r            <= 8'h18;
			work_r              <= 8'h00;
			bank_sel_r          <= 5'h00;
			pc_high_latch_r     <= 7'h00;
			pointer0_r          <= 16'h0000;
			pointer1_r          <= 16'h0000;
			global_irq_enable_r <= 1'b0;
			gie_hold_r          <= 1'b0;
			file_wdata_r        <= 8'h00;
			file_we_r           <= 1'b0;
			file_read_r         <= 8'h00;
		end else begin
			// one-cycle strobes drop unless an instruction raises them
			file_we_r   <= 1'b0;
			gie_hold_r  <= 1'b0;
			file_read_r <= file_val;
			case (state_r)
			ST_RUN: begin
				if (take_irq) begin
					// vector; pc saved by the stack
					global_irq_enable_r <= 1'b0;
					pc_r    <= `IRQ_VECTOR;
					state_r <= ST_IRQ;
				end else begin
					// normal step; branches and returns override it
					pc_r <= pc_r + 15'h0001;
					case (op_kind)
					`OP_LOAD_BANK:
						bank_sel_r <= literal[4:0]; // RQ1
					`OP_LOAD_PAGE:
						pc_high_latch_r <= literal[6:0]; // RQ2
					`OP_JUMP, `OP_CALL:
						// window target with latch upper bits
						pc_r <= {pc_high_latch_r[6:3],
							literal}; // RQ3 RQ4
					`OP_RETURN:
						pc_r <= stack_top; // RQ20
					`OP_RET_IRQ: begin
						// restore the saved context, software edits too
						pc_r                <= stack_top;
						global_irq_enable_r <= 1'b1; // RQ20
						status_r   <= shadow_r[0]; // RQ11
						work_r     <= shadow_r[1];
						bank_sel_r <= shadow_r[2][4:0];
						pc_high_latch_r <= shadow_r[3][6:0];
						pointer0_r <= {shadow_r[5], shadow_r[4]};
						pointer1_r <= {shadow_r[7], shadow_r[6]};
					end
					`OP_SET_GIE: begin
						// hold blocks entry for exactly one instruction
						global_irq_enable_r <= 1'b1;
						gie_hold_r          <= 1'b1; // RQ17
					end
					`OP_ALU_FILE: begin
						// flags follow every result; it lands in w or a file
						status_r[`ST_CARRY] <= alu_c;
						status_r[`ST_DIGIT] <= alu_dc;
						status_r[`ST_ZERO]  <= alu_res == 8'h00;
						if (!dest_file)
							work_r <= alu_res;
						else if (file_addr == `ADDR_WORK_REG)
							work_r <= alu_res; // RQ10
						else if (file_addr == `ADDR_PTR0_LOW)
							pointer0_r[7:0] <= alu_res;
						else if (file_addr == `ADDR_PTR0_HIGH)
							pointer0_r[15:8] <= alu_res; // RQ18
						else if (file_addr == `ADDR_PTR1_LOW)
							pointer1_r[7:0] <= alu_res;
						else if (file_addr == `ADDR_PTR1_HIGH)
							pointer1_r[15:8] <= alu_res; // RQ18
						else begin
							file_wdata_r <= alu_res;
							file_we_r    <= 1'b1;
						end
					end
					`OP_WRITE_FILE: begin
						// shadow writes are taken in the shadow block instead
						if (file_addr == `ADDR_WORK_REG)
							work_r <= write_data; // RQ10
						else if (file_addr == `ADDR_BANK_SEL)
							bank_sel_r <= write_data[4:0];
						else if (file_addr == `ADDR_PC_HIGH)
							pc_high_latch_r <= write_data[6:0];
						else if (file_addr == `ADDR_PTR0_HIGH)
							pointer0_r[15:8] <= write_data; // RQ18
						else if (file_addr == `ADDR_PTR1_HIGH)
							pointer1_r[15:8] <= write_data; // RQ18
						else if (file_addr == `ADDR_PTR0_LOW)
							pointer0_r[7:0] <= write_data;
						else if (file_addr == `ADDR_PTR1_LOW)
							pointer1_r[7:0] <= write_data;
						else if (!is_shadow) begin
							file_wdata_r <= write_data;
							file_we_r    <= 1'b1;
						end
					end
					default: ;
					endcase
				end
			end
			ST_IRQ:
				// one dead cycle while the vector is fetched
				state_r <= ST_RUN;
			default:
				state_r <= ST_RUN;
			endcase
		end
	end
endmodule // core_ext

// *** verif/core_ext_assertions.sv ***
// concurrent checks on the enhanced core ports
`include "core_ext_regs.vh"
module core_ext_assertions (
	input wire        clk,
	input wire        rst,
	input wire        power_on,
	input wire        irq_req,
	input wire [3:0]  op_kind,
	input wire [10:0] literal,
	input wire [14:0] pc_r,
	input wire [4:0]  bank_sel_r,
	input wire [6:0]  pc_high_latch_r,
	input wire        global_irq_enable_r,
	input wire [4:0]  reset_cause_r,
	input wire        core_reset_r
);
timeunit 1ns;
timeprecision 1ps;
	logic gie_d_r;
	wire  live;
	// delayed enable marks the dead cycle that follows interrupt entry
	always @(posedge clk) begin
		gie_d_r <= rst ? 1'b0 : global_irq_enable_r;
	end
	// ops are void at internal reset, at entry and in the dead cycle
	assign live = !core_reset_r && !(irq_req && global_irq_enable_r)
		&& !(gie_d_r && !global_irq_enable_r);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////
	AST_BANK_LOAD: assert property (
		live && op_kind == `OP_LOAD_BANK
		|=> bank_sel_r == $past(literal[4:0])) else $error("bank load");
	AST_PAGE_LOAD: assert property (
		live && op_kind == `OP_LOAD_PAGE
		|=> pc_high_latch_r == $past(literal[6:0])) else $error("page load");
	AST_JUMP_TARGET: assert property (
		live && op_kind == `OP_JUMP |=> pc_r ==
		{$past(pc_high_latch_r[6:3]), $past(literal)}) else $error("jump");
	AST_IRQ_VECTOR: assert property (
		$fell(global_irq_enable_r) && !$past(core_reset_r)
		|-> pc_r == `IRQ_VECTOR) else $error("irq vector");
	AST_RETI_ENABLE: assert property (
		live && op_kind == `OP_RET_IRQ |=> global_irq_enable_r)
		else $error("return from irq left enable low");
	AST_RET_NO_ENABLE: assert property (
		live && op_kind == `OP_RETURN && !global_irq_enable_r
		|=> !global_irq_enable_r) else $error("plain return set enable");
	AST_SW_RESET: assert property (
		live && op_kind == `OP_SW_RESET
		|-> ##[1:2] core_reset_r && reset_cause_r[2]) else $error("sw reset");
	AST_CORE_CLEAR: assert property (
		core_reset_r |=> bank_sel_r == 5'h00 && !global_irq_enable_r)
		else $error("core reset did not clear state");
	AST_CAUSE_STICKY: assert property (
		(reset_cause_r & $past(reset_cause_r)) == $past(reset_cause_r))
		else $error("reset cause flag dropped");
	AST_POWER_CAUSE: assert property (
		power_on |-> ##[1:2] reset_cause_r[3]) else $error("power cause");
	// main scenarios reached
	cover property (live && op_kind == `OP_JUMP);
	cover property ($fell(global_irq_enable_r));
	cover property (core_reset_r && reset_cause_r[1]);
endmodule // core_ext_assertions

bind core_ext core_ext_assertions checks (
	.clk(clk), .rst(rst), .power_on(power_on), .irq_req(irq_req),
	.op_kind(op_kind), .literal(literal), .pc_r(pc_r),
	.bank_sel_r(bank_sel_r), .pc_high_latch_r(pc_high_latch_r),
	.global_irq_enable_r(global_irq_enable_r),
	.reset_cause_r(reset_cause_r), .core_reset_r(core_reset_r)
);

// *** verif/tb_core_ext.sv ***
// self-checking bench for the enhanced core
`include "core_ext_regs.vh"
module tb_core_ext;
timeunit 1ns;
timeprecision 1ps;
	logic        clk, rst, power_on, external_clear_pin, stack_reset_en;
	logic        irq_req, dest_file, c, global_irq_enable_r;
	logic        file_we_r, core_reset_r;
	logic [3:0]  op_kind, alu_op, k;
	logic [10:0] literal, b, l;
	logic [6:0]  file_addr, pc_high_latch_r;
	logic [7:0]  file_rdata, write_data, status_r, work_r, w, n, f;
	logic [7:0]  file_wdata_r, file_read_r;
	logic [14:0] pc_r;
	logic [4:0]  bank_sel_r, reset_cause_r;
	logic [15:0] pointer0_r, pointer1_r, p0, p1;
	logic [55:0] sh;
	int          err_total, check_count, cyc, i, j;

	core_ext dut (
		.clk(clk), .rst(rst), .power_on(power_on),
		.external_clear_pin(external_clear_pin),
		.stack_reset_en(stack_reset_en), .irq_req(irq_req),
		.op_kind(op_kind), .alu_op(alu_op), .literal(literal),
		.file_addr(file_addr), .dest_file(dest_file),
		.file_rdata(file_rdata), .write_data(write_data), .pc_r(pc_r),
		.status_r(status_r), .work_r(work_r), .bank_sel_r(bank_sel_r),
		.pc_high_latch_r(pc_high_latch_r), .pointer0_r(pointer0_r),
		.pointer1_r(pointer1_r),
		.global_irq_enable_r(global_irq_enable_r),
		.file_wdata_r(file_wdata_r), .file_we_r(file_we_r),
		.reset_cause_r(reset_cause_r), .core_reset_r(core_reset_r),
		.file_read_r(file_read_r)
	);
	////////////////////////////////////////////////////////////////////
	// verdict, reached from the main sequence or the hang guard
	task automatic close_out();
		if (err_total == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// x-safe compare, narrow values are zero extended
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one instruction, taken at the next rising edge
	task automatic go(input logic [3:0] op, input logic [10:0] v,
		input logic [6:0] a);
		op_kind = op;
		literal = v;
		file_addr = a;
		@(negedge clk);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		write_data = d;
		go(`OP_WRITE_FILE, 11'h000, a);
	endtask
	// internal reset shows as bank select returning to zero
	task automatic settle();
		repeat (6) if (bank_sel_r !== 5'h00) go(`OP_NONE, 11'h000, 7'h00);
	endtask
	// expected {carry, result}; subtract carry means no borrow
	function automatic logic [8:0] ref_alu(input logic [3:0] op,
		input logic [7:0] fv, input logic [7:0] v, input logic ci);
		case (op)
		`ALU_ADD:   return {1'b0, fv} + v;
		`ALU_ADDC:  return {1'b0, fv} + v + ci;
		`ALU_SUB:   return {1'b1, fv} - v;
		`ALU_SUBB:  return {1'b1, fv} - v - !ci;
		`ALU_ROT_L: return {fv, ci};
		`ALU_ROT_R: return {fv[0], ci, fv[7:1]};
		`ALU_ASR:   return {fv[0], fv[7], fv[7:1]};
		`ALU_LSR:   return {fv[0], 1'b0, fv[7:1]};
		default:    return {fv, 1'b0};
		endcase
	endfunction
	// file operand is the work register when addressed as a file
	task automatic calc(input logic [3:0] op, input logic [6:0] a,
		input logic [7:0] fv);
		logic [8:0] r;
		r = ref_alu(op, a == `ADDR_WORK_REG ? w : fv, w, c);
		alu_op = op;
		file_rdata = fv;
		go(`OP_ALU_FILE, 11'h000, a);
		{c, w} = r;
		chk("work", work_r, w);
		chk("carry", status_r[`ST_CARRY], c);
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// hang guard, far above the under two hundred cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			close_out();
		end
	end
	initial begin
		void'($urandom(32'h1317));
		{rst, power_on, external_clear_pin, stack_reset_en} = 4'h8;
		{irq_req, dest_file, op_kind, alu_op, literal} = '0;
		{file_addr, file_rdata, write_data, w, c} = '0;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		chk("status", status_r, 8'h18);
		// banking and paging, first pass at the top literal values
		for (i = 0; i < 8; i++) begin
			b = (i == 0) ? 11'h7ff : 11'($urandom);
			l = (i == 0) ? 11'h07f : 11'($urandom);
			go(`OP_LOAD_BANK, b, 7'h00);
			chk("bank", bank_sel_r, b[4:0]);
			go(`OP_LOAD_PAGE, l, 7'h00);
			chk("latch", pc_high_latch_r, l[6:0]);
			go(i[0] ? `OP_JUMP : `OP_CALL, b, 7'h00);
			chk("target", pc_r, {l[6:3], b});
		end
		go(`OP_RETURN, 11'h000, 7'h00);
		chk("enable", global_irq_enable_r, 0);
		// alu: shift corner values first, then random mixes
		w = 8'($urandom);
		wr(`ADDR_WORK_REG, w);
		for (i = 0; i < 60; i++) begin
			f = 8'($urandom);
			k = 4'($urandom_range(8));
			if (i < 6) begin
				f = i[0] ? 8'h80 : 8'h7f;
				k = 4'(`ALU_ASR + i / 2);
			end
			calc(k, 7'h20, f);
		end
		// rotates write back through the work register's file address
		dest_file = 1'b1;
		for (j = 0; j < 2; j++) begin
			n = w;
			repeat (9) calc(j ? `ALU_ROT_R : `ALU_ROT_L, `ADDR_WORK_REG,
				8'($urandom));
			chk("nine", work_r, n);
		end
		// file destination: result leaves on the outside write port
		f = 8'($urandom);
		{c, n} = ref_alu(`ALU_ADDC, f, w, c);
		alu_op = `ALU_ADDC;
		file_rdata = f;
		go(`OP_ALU_FILE, 11'h000, 7'h20);
		dest_file = 1'b0;
		chk("file_we", file_we_r, 1);
		chk("file_wdata", file_wdata_r, n);
		chk("work_kept", work_r, w);
		chk("carry", status_r[`ST_CARRY], c);
		// context save: op after enabling runs before entry
		p0 = 16'($urandom);
		p1 = 16'($urandom);
		wr(`ADDR_PTR0_LOW, p0[7:0]);
		wr(`ADDR_PTR0_HIGH, p0[15:8]);
		wr(`ADDR_PTR1_LOW, p1[7:0]);
		wr(`ADDR_PTR1_HIGH, p1[15:8]);
		chk("ptr0", pointer0_r, p0);
		chk("ptr1", pointer1_r, p1);
		go(`OP_LOAD_PAGE, l, 7'h00);
		irq_req = 1'b1;
		go(`OP_SET_GIE, 11'h000, 7'h00);
		go(`OP_LOAD_BANK, 11'h01f, 7'h00);
		chk("bank", bank_sel_r, 5'h1f);
		repeat (4) if (global_irq_enable_r === 1'b1) go(`OP_NONE, 0, 7'h00);
		irq_req = 1'b0;
		chk("vector", pc_r, `IRQ_VECTOR);
		go(`OP_NONE, 11'h000, 7'h00);
		sh = {p1, p0, 1'b0, l[6:0], 8'h1f, w};
		for (j = 1; j < 8; j++) begin
			go(`OP_NONE, 11'h000, 7'(7'h64 + j));
			chk("shadow", file_read_r, sh[(j - 1) * 8 +: 8]);
		end
		n = 8'($urandom);
		wr(7'h65, n);
		wr(`ADDR_WORK_REG, ~n);
		go(`OP_LOAD_BANK, 11'h003, 7'h00);
		go(`OP_RET_IRQ, 11'h000, 7'h00);
		chk("work", work_r, n);
		chk("bank", bank_sel_r, 5'h1f);
		chk("ptr1", pointer1_r, p1);
		chk("enable", global_irq_enable_r, 1);
		// reset causes: power, pin, instruction, then stack faults
		power_on = 1'b1;
		go(`OP_NONE, 11'h000, 7'h00);
		power_on = 1'b0;
		external_clear_pin = 1'b1;
		go(`OP_NONE, 11'h000, 7'h00);
		external_clear_pin = 1'b0;
		go(`OP_SW_RESET, 11'h000, 7'h00);
		settle();
		chk("cause", reset_cause_r, 5'h1c);
		stack_reset_en = 1'b1;
		go(`OP_LOAD_BANK, 11'h005, 7'h00);
		go(`OP_RETURN, 11'h000, 7'h00);
		settle();
		chk("cause", reset_cause_r, 5'h1e);
		go(`OP_LOAD_BANK, 11'h005, 7'h00);
		repeat (17) go(`OP_CALL, 11'($urandom), 7'h00);
		settle();
		chk("cause", reset_cause_r, 5'h1f);
		close_out();
	end
endmodule // tb_core_ext
